// ---- verilog/asri_top.sv ----
// Contract
// - Input bits sampled on falling SCLK, output bits changed on rising SCLK.
// - Chip select high puts combined output pin in high impedance.
// - Combined pin falls together with conversion-ready while selected, until the first rising SCLK starts shifting.
// - Autoreset: fewer than seven transitions within 65536 cycles resets interface.
// - Seven transitions in time: no reset, detection restarts next transition.
// - Autoreset only when configuration bit 3 set; off by default.
// - Conversion-ready starts high after power-on.
// - Continuous mode: ready returns high at first falling SCLK edge.
// - Unread result: ready pulses high 16 cycles before next ready fall.
// - Direct readback must end 16 cycles before next ready fall.
// - Pulse mode: ready high at conversion start, low when result ready.
// - New-data status bit shows result changed since host's last read.
// - Auxiliary new-data bit meaningful only for command readback.
// - Primary results go to shift register and holding; auxiliary to holding.
// - Direct readback needs no opcode; host stays quiet after ready falls.
// - Input bits decoded and commands executed during direct readback.
// - Result during a transfer skips shift register, goes to holding only.
// - Conversion restart clears primary holding register.
// - Direct frame is status, four data bytes, checksum; repeats by SCLK.
// - Chip select high holds interface reset and ignores SCLK.
module asri_top #(
	parameter int         TIMEOUT_CYC = asri_pkg::TIMEOUT_CLK,
	parameter logic [7:0] CHK_SEED    = 8'h9B
) (
	// Converter clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	// Serial pins
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        serial_in_i,
	output logic             serial_out_ready_combined_o,
	output logic             serial_out_ready_combined_oe_o,
	output logic             conversion_ready_n_o,
	// Configuration
	input  wire logic [7:0]  iface_cfg_i,
	input  wire logic        continuous_mode_i,
	input  wire logic        conv_start_i,
	input  wire logic        conv_restart_i,
	input  wire logic [5:0]  status_misc_i,
	// Converter results
	input  wire logic        primary_valid_i,
	input  wire logic [31:0] primary_data_i,
	input  wire logic        auxiliary_valid_i,
	input  wire logic [23:0] auxiliary_data_i,
	// Status
	output logic             primary_new_o,
	output logic             auxiliary_new_o,
	output logic             iface_reset_o
);

	////////////////////////////////////////////////////////////////////////////
	// Link domain (SCLK)

	logic                    link_rst_n;
	logic                    iface_rst_r;
	logic [6:0]              rx_sh_r;
	logic [2:0]              rx_cnt_r;
	logic                    fall_tg_r;
	logic                    rise_tg_r;
	logic                    cmd_tg_r;
	logic                    rd_prim_tg_r;
	logic                    rd_aux_tg_r;
	asri_pkg::asri_sel_t     sel_r;
	logic                    seen_tg_r;
	logic                    active_r;
	logic [5:0]              pos_r;
	logic                    tx_bit_r;
	logic                    rd_dir_tg_r;
	logic [47:0]             dir_frame_r;
	logic [47:0]             cmd_frame_r;
	logic [47:0]             aux_frame_r;
	logic [5:0]              frame_len_r;
	wire  logic [7:0]        rx_byte;
	wire  logic              is_rd_prim;
	wire  logic              is_rd_aux;
	wire  logic [47:0]       tx_frame;
	wire  logic              new_cmd;
	wire  logic [5:0]        pos_use;
	wire  logic [5:0]        pos_next;
	wire  logic              link_busy;

	// interface reset by select or autoreset
	assign link_rst_n = rst_n_i & ~cs_n_i & ~iface_rst_r;

	assign rx_byte    = {rx_sh_r, serial_in_i};
	assign is_rd_prim = (rx_cnt_r == 3'h7) &&
		((rx_byte & asri_pkg::CMD_MASK) == asri_pkg::CMD_READ_PRIMARY);
	assign is_rd_aux  = (rx_cnt_r == 3'h7) &&
		((rx_byte & asri_pkg::CMD_MASK) == asri_pkg::CMD_READ_AUX);

	// input sampled on falling edge, decoded even while reading out
	always_ff @(negedge sclk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rx_sh_r  <= 7'h00;
			rx_cnt_r <= 3'h0;
			sel_r    <= asri_pkg::ASRI_SEL_DIRECT;
		end else begin
			rx_sh_r  <= rx_byte[6:0];
			rx_cnt_r <= rx_cnt_r + 3'h1;
			if (is_rd_prim) begin
				sel_r <= asri_pkg::ASRI_SEL_PRIMARY;
			end else if (is_rd_aux) begin
				sel_r <= asri_pkg::ASRI_SEL_AUX;
			end
		end
	end

	// Event toggles survive interface resets so the core sees no false edge
	always_ff @(negedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fall_tg_r    <= 1'b0;
			cmd_tg_r     <= 1'b0;
			rd_prim_tg_r <= 1'b0;
			rd_aux_tg_r  <= 1'b0;
		end else if (!cs_n_i) begin
			fall_tg_r <= ~fall_tg_r;
			if (is_rd_prim || is_rd_aux) begin
				cmd_tg_r <= ~cmd_tg_r;
			end
			if (is_rd_prim) begin
				rd_prim_tg_r <= ~rd_prim_tg_r;
			end
			if (is_rd_aux) begin
				rd_aux_tg_r <= ~rd_aux_tg_r;
			end
		end
	end

	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rise_tg_r <= 1'b0;
		end else if (!cs_n_i) begin
			rise_tg_r <= ~rise_tg_r;
		end
	end

	assign tx_frame = (sel_r == asri_pkg::ASRI_SEL_PRIMARY) ? cmd_frame_r :
	                  (sel_r == asri_pkg::ASRI_SEL_AUX)     ? aux_frame_r : dir_frame_r;
	assign new_cmd  = (cmd_tg_r != seen_tg_r);
	assign pos_use  = new_cmd ? 6'h00 : pos_r;
	// frame repeats from its first byte
	assign pos_next = (pos_use + 6'h01 >= frame_len_r) ? 6'h00 : pos_use + 6'h01;

	// output bit changes on rising edge, MSB first
	always_ff @(posedge sclk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			seen_tg_r   <= 1'b0;
			active_r    <= 1'b0;
			pos_r       <= 6'h00;
			tx_bit_r    <= 1'b0;
		end else begin
			seen_tg_r <= cmd_tg_r;
			active_r  <= 1'b1;
			pos_r     <= pos_next;
			tx_bit_r  <= tx_frame[6'd47 - pos_use];
		end
	end

	// Direct-read event for the new-data flag
	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_dir_tg_r <= 1'b0;
		end else if (!cs_n_i && !iface_rst_r && !active_r &&
		             sel_r == asri_pkg::ASRI_SEL_DIRECT) begin
			rd_dir_tg_r <= ~rd_dir_tg_r;
		end
	end

	assign link_busy = active_r | (rx_cnt_r != 3'h0);

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers into the converter clock domain

	logic [1:0]              fall_s_r;
	logic [1:0]              rise_s_r;
	logic [1:0]              busy_s_r;
	logic [1:0]              cs_s_r;
	logic [1:0]              rdp_s_r;
	logic [1:0]              rda_s_r;
	logic [1:0]              rdd_s_r;
	logic                    fall_d_r;
	logic                    rise_d_r;
	logic                    rdp_d_r;
	logic                    rda_d_r;
	logic                    rdd_d_r;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fall_s_r <= 2'b00;
			rise_s_r <= 2'b00;
			busy_s_r <= 2'b00;
			cs_s_r   <= 2'b11;
			rdp_s_r  <= 2'b00;
			rda_s_r  <= 2'b00;
			rdd_s_r  <= 2'b00;
			fall_d_r <= 1'b0;
			rise_d_r <= 1'b0;
			rdp_d_r  <= 1'b0;
			rda_d_r  <= 1'b0;
			rdd_d_r  <= 1'b0;
		end else begin
			fall_s_r <= {fall_s_r[0], fall_tg_r};
			rise_s_r <= {rise_s_r[0], rise_tg_r};
			busy_s_r <= {busy_s_r[0], link_busy};
			cs_s_r   <= {cs_s_r[0], cs_n_i};
			rdp_s_r  <= {rdp_s_r[0], rd_prim_tg_r};
			rda_s_r  <= {rda_s_r[0], rd_aux_tg_r};
			rdd_s_r  <= {rdd_s_r[0], rd_dir_tg_r};
			fall_d_r <= fall_s_r[1];
			rise_d_r <= rise_s_r[1];
			rdp_d_r  <= rdp_s_r[1];
			rda_d_r  <= rda_s_r[1];
			rdd_d_r  <= rdd_s_r[1];
		end
	end

	wire  logic              fall_ev;
	wire  logic              rise_ev;
	wire  logic              edge_ev;
	wire  logic              busy;
	wire  logic              rd_prim_ev;
	wire  logic              rd_aux_ev;

	assign fall_ev    = fall_s_r[1] ^ fall_d_r;
	assign rise_ev    = rise_s_r[1] ^ rise_d_r;
	assign edge_ev    = fall_ev | rise_ev;
	assign busy       = busy_s_r[1];
	assign rd_prim_ev = (rdp_s_r[1] ^ rdp_d_r) | (rdd_s_r[1] ^ rdd_d_r);
	assign rd_aux_ev  = rda_s_r[1] ^ rda_d_r;

	////////////////////////////////////////////////////////////////////////////
	// Autoreset timeout

	asri_pkg::asri_to_t      to_st_r;
	asri_pkg::asri_to_t      to_st_nxt;
	logic [16:0]             to_cnt_r;
	logic [2:0]              to_edges_r;
	wire  logic              to_en;
	wire  logic              to_expired;

	assign to_en      = iface_cfg_i[asri_pkg::CFG_TIMEOUT_BIT] & ~cs_s_r[1];
	assign to_expired = (to_cnt_r >= 17'(TIMEOUT_CYC - 1));

	always_comb begin
		to_st_nxt = to_st_r;
		case (to_st_r)
			asri_pkg::ASRI_TO_IDLE: begin
				if (to_en && rise_ev) begin
					to_st_nxt = asri_pkg::ASRI_TO_COUNT;
				end
			end
			asri_pkg::ASRI_TO_COUNT: begin
				// seven transitions in time, detection rearms
				if (!to_en) begin
					to_st_nxt = asri_pkg::ASRI_TO_IDLE;
				end else if (edge_ev && to_edges_r == 3'(asri_pkg::EDGE_LIMIT - 1)) begin
					to_st_nxt = asri_pkg::ASRI_TO_ARMED;
				end else if (to_expired) begin
					to_st_nxt = asri_pkg::ASRI_TO_RESET;
				end
			end
			asri_pkg::ASRI_TO_ARMED: begin
				if (!to_en) begin
					to_st_nxt = asri_pkg::ASRI_TO_IDLE;
				end else if (edge_ev) begin
					to_st_nxt = asri_pkg::ASRI_TO_COUNT;
				end
			end
			asri_pkg::ASRI_TO_RESET: begin
				if (to_cnt_r == 17'(asri_pkg::RECOVER_CLK - 1)) begin
					to_st_nxt = asri_pkg::ASRI_TO_IDLE;
				end
			end
			default: to_st_nxt = asri_pkg::ASRI_TO_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			to_st_r     <= asri_pkg::ASRI_TO_IDLE;
			to_cnt_r    <= 17'h00000;
			to_edges_r  <= 3'h0;
			iface_rst_r <= 1'b0;
		end else begin
			to_st_r     <= to_st_nxt;
			// reset held four cycles before the next transaction
			iface_rst_r <= (to_st_nxt == asri_pkg::ASRI_TO_RESET);
			if (to_st_nxt != to_st_r) begin
				to_cnt_r   <= 17'h00000;
				to_edges_r <= 3'h0;
			end else begin
				to_cnt_r <= to_cnt_r + 17'h00001;
				if (edge_ev) begin
					to_edges_r <= to_edges_r + 3'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Results, ready signal and frames

	logic [31:0]             stage_r;
	logic [31:0]             hold_prim_r;
	logic [23:0]             hold_aux_r;
	logic                    new_prim_r;
	logic                    new_aux_r;
	logic                    conversion_ready_n_r;
	logic                    pulsing_r;
	logic [4:0]              pulse_cnt_r;
	wire  logic              unread;
	wire  logic              load_now;
	wire  logic              pulse_done;
	wire  logic              stat_en;
	wire  logic              chk_en;
	wire  logic [7:0]        status_byte;
	wire  logic [47:0]       prim_frame;
	wire  logic [47:0]       aux_frame;
	wire  logic [47:0]       stage_frame;
	wire  logic [5:0]        frame_len;

	assign unread     = continuous_mode_i & ~conversion_ready_n_r;
	assign pulse_done = pulsing_r && (pulse_cnt_r == 5'(asri_pkg::READY_PULSE_CLK - 1));
	assign load_now   = (primary_valid_i && !unread && !pulsing_r) || pulse_done;

	assign stat_en     = iface_cfg_i[asri_pkg::CFG_STATUS_BIT];
	assign chk_en      = |iface_cfg_i[asri_pkg::CFG_CHK_MSB:asri_pkg::CFG_CHK_LSB];
	assign status_byte = {new_aux_r, new_prim_r, status_misc_i};
	assign frame_len   = 6'((asri_pkg::BASE_BYTES + 32'(stat_en) + 32'(chk_en)) * 8);

	function automatic logic [47:0] build_frame(input logic [31:0] d, input logic [7:0] st,
	                                            input logic s_en, input logic c_en);
		logic [7:0]  chk;
		logic [47:0] f;
		chk = d[31:24] + d[23:16] + d[15:8] + d[7:0] + CHK_SEED;
		if (s_en) begin
			f = {st, d, (c_en ? chk : 8'h00)};
		end else begin
			f = {d, (c_en ? chk : 8'h00), 8'h00};
		end
		return f;
	endfunction

	assign prim_frame  = build_frame(hold_prim_r, status_byte, stat_en, chk_en);
	assign aux_frame   = build_frame({hold_aux_r, asri_pkg::AUX_PAD}, status_byte,
	                                 stat_en, chk_en);
	assign stage_frame = build_frame(stage_r, status_byte | 8'h40, stat_en, chk_en);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage_r     <= 32'h00000000;
			hold_prim_r <= 32'h00000000;
			hold_aux_r  <= 24'h000000;
			new_prim_r  <= 1'b0;
			new_aux_r   <= 1'b0;
			conversion_ready_n_r      <= 1'b1;
			pulsing_r   <= 1'b0;
			pulse_cnt_r <= 5'h00;
			dir_frame_r <= 48'h000000000000;
			cmd_frame_r <= 48'h000000000000;
			aux_frame_r <= 48'h000000000000;
			frame_len_r <= 6'h20;
		end else begin
			if (primary_valid_i) begin
				stage_r <= primary_data_i;
			end
			// high pulse before replacing an unread result
			if (primary_valid_i && unread && !pulsing_r) begin
				pulsing_r   <= 1'b1;
				pulse_cnt_r <= 5'h00;
				conversion_ready_n_r      <= 1'b1;
			end else if (pulsing_r) begin
				pulse_cnt_r <= pulse_cnt_r + 5'h01;
				if (pulse_done) begin
					pulsing_r <= 1'b0;
				end
			end
			if (load_now) begin
				conversion_ready_n_r      <= 1'b0;
				hold_prim_r <= pulse_done ? stage_r : primary_data_i;
			// pulse mode: high at conversion start
			end else if (!continuous_mode_i && conv_start_i) begin
				conversion_ready_n_r <= 1'b1;
			// continuous mode: high at first falling edge
			end else if (continuous_mode_i && fall_ev && !pulsing_r) begin
				conversion_ready_n_r <= 1'b1;
			end
			// restart clears the primary holding register
			if (conv_restart_i && !load_now) begin
				hold_prim_r <= 32'h00000000;
			end
			if (load_now) begin
				new_prim_r <= 1'b1;
			end else if (rd_prim_ev || conv_restart_i) begin
				new_prim_r <= 1'b0;
			end
			// auxiliary result only to its holding register
			if (auxiliary_valid_i) begin
				hold_aux_r <= auxiliary_data_i;
				new_aux_r  <= 1'b1;
			end else if (rd_aux_ev) begin
				new_aux_r <= 1'b0;
			end
			// frames change only while the link is idle
			if (!busy) begin
				cmd_frame_r <= prim_frame;
				aux_frame_r <= aux_frame;
				frame_len_r <= frame_len;
				if (load_now) begin
					dir_frame_r <= pulse_done ? stage_frame :
						build_frame(primary_data_i, status_byte | 8'h40, stat_en, chk_en);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pins

	// tri-state while deselected, ready shown until shifting begins
	assign serial_out_ready_combined_o    = active_r ? tx_bit_r : conversion_ready_n_r;
	assign serial_out_ready_combined_oe_o = ~cs_n_i;
	assign conversion_ready_n_o           = conversion_ready_n_r;
	assign primary_new_o                  = new_prim_r;
	assign auxiliary_new_o                = new_aux_r;
	assign iface_reset_o                  = iface_rst_r;

endmodule

// ---- verilog/asri_pkg.sv ----
package asri_pkg;

	// Interface autoreset timing in converter clock cycles, and the SCLK transition count
	localparam int          TIMEOUT_CLK     = 65536;
	localparam int          RECOVER_CLK     = 4;
	localparam int          EDGE_LIMIT      = 7;

	// Ready pulse ahead of an unread result being replaced
	localparam int          READY_PULSE_CLK = 16;

	// Interface configuration byte layout
	localparam int          CFG_TIMEOUT_BIT = 3;
	localparam int          CFG_STATUS_BIT  = 2;
	localparam int          CFG_CHK_LSB     = 0;
	localparam int          CFG_CHK_MSB     = 1;
	localparam logic [7:0]  CFG_RESET       = 8'h00;

	// Read commands; bit 0 is ignored
	localparam logic [7:0]  CMD_READ_PRIMARY = 8'h12;
	localparam logic [7:0]  CMD_READ_AUX     = 8'h14;
	localparam logic [7:0]  CMD_MASK         = 8'hFE;

	// Frame layout
	localparam int          FRAME_BITS      = 48;
	localparam int          BASE_BYTES      = 4;
	localparam logic [7:0]  AUX_PAD         = 8'h00;
	localparam int          STAT_PRIM_BIT   = 6;
	localparam int          STAT_AUX_BIT    = 7;

	typedef enum {
		ASRI_SEL_DIRECT,
		ASRI_SEL_PRIMARY,
		ASRI_SEL_AUX
	} asri_sel_t;

	typedef enum {
		ASRI_TO_IDLE,
		ASRI_TO_COUNT,
		ASRI_TO_ARMED,
		ASRI_TO_RESET
	} asri_to_t;

endpackage

// ---- verification/asri_assertions.sv ----
module asri_assertions #(
	parameter int TIMEOUT_CYC = 65536
) (
	// Clock and reset
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	// Serial pins
	input wire logic        sclk_i,
	input wire logic        cs_n_i,
	input wire logic        serial_in_i,
	input wire logic        serial_out_ready_combined_o,
	input wire logic        serial_out_ready_combined_oe_o,
	input wire logic        conversion_ready_n_o,
	// Configuration
	input wire logic [7:0]  iface_cfg_i,
	input wire logic        continuous_mode_i,
	input wire logic        conv_start_i,
	input wire logic        conv_restart_i,
	input wire logic [5:0]  status_misc_i,
	// Results and status
	input wire logic        primary_valid_i,
	input wire logic [31:0] primary_data_i,
	input wire logic        auxiliary_valid_i,
	input wire logic [23:0] auxiliary_data_i,
	input wire logic        primary_new_o,
	input wire logic        auxiliary_new_o,
	input wire logic        iface_reset_o
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	logic fresh_r;

	// Selection with no sclk rise seen yet
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fresh_r <= 1'b1;
		end else if (cs_n_i) begin
			fresh_r <= 1'b1;
		end else if (sclk_i) begin
			fresh_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	sequence s_high16;
		conversion_ready_n_o [*8] ##1 conversion_ready_n_o [*8];
	endsequence

	sequence s_reset4;
		iface_reset_o [*4] ##1 !iface_reset_o;
	endsequence

	a_pin_tristate: assert property (serial_out_ready_combined_oe_o == !cs_n_i)
		else $error("pin enable does not follow chip select");
	a_pin_ready: assert property (fresh_r && !cs_n_i && !sclk_i |->
		serial_out_ready_combined_o == conversion_ready_n_o)
		else $error("combined pin differs from ready");
	a_ready_power: assert property ($rose(rst_n_i) |-> conversion_ready_n_o)
		else $error("ready low after reset");
	a_sclk_clear: assert property (continuous_mode_i && !cs_n_i && !iface_reset_o
		&& $fell(sclk_i) |-> ##[0:6] conversion_ready_n_o)
		else $error("ready not raised by sclk fall");
	a_unread_pulse: assert property (continuous_mode_i && !conversion_ready_n_o
		&& primary_valid_i |=> s_high16 ##1 !conversion_ready_n_o)
		else $error("unread pulse wrong");
	a_cont_fall: assert property (continuous_mode_i && conversion_ready_n_o
		&& primary_valid_i |=> !conversion_ready_n_o)
		else $error("ready did not fall");
	a_pulse_low: assert property (!continuous_mode_i && primary_valid_i
		&& !conv_start_i |=> !conversion_ready_n_o)
		else $error("pulse mode ready did not fall");
	a_pulse_start: assert property (!continuous_mode_i && conv_start_i
		&& !primary_valid_i |=> conversion_ready_n_o)
		else $error("start did not raise ready");
	a_reset_four: assert property ($rose(iface_reset_o) |-> s_reset4)
		else $error("autoreset length wrong");
	a_reset_enabled: assert property ($rose(iface_reset_o) |-> iface_cfg_i[3] && !cs_n_i)
		else $error("autoreset while disabled");
	a_new_set: assert property (primary_valid_i |=> primary_new_o)
		else $error("primary new flag not set");
	a_aux_set: assert property (auxiliary_valid_i |=> auxiliary_new_o)
		else $error("auxiliary new flag not set");
	a_restart_clear: assert property (conv_restart_i && !primary_valid_i |=> !primary_new_o)
		else $error("restart kept new flag");
endmodule

// ---- verification/asri_host_model.sv ----
module asri_host_model (
	// Serial pins toward the device
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o,
	// Combined pin from the device
	input wire logic  dout_i,
	input wire logic  dout_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end

	task automatic sel(input logic v);
		#48;
		cs_n_o = v;
		#48;
	endtask

	// drive on rise, sample on fall
	task automatic bits(input logic [7:0] tx, input int n, inout logic [7:0] rx);
		for (int i = 0; i < n; i++) begin
			sclk_o = 1'b1;
			din_o = tx[7];
			#24;
			rx = {rx[6:0], dout_oe_i ? dout_i : 1'bx};
			sclk_o = 1'b0;
			#12;
			// clock rests low, data low, away from any edge
			if (i == n - 1) begin
				din_o = 1'b0;
			end
			#12;
			tx = tx << 1;
		end
	endtask
endmodule

// ---- verification/asri_top_tb_top.sv ----
module asri_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int         TO   = 64;
	localparam logic [7:0] SEED = 8'h5A;

	logic        clock_i, rst_n_i, sclk, cs_n, din, pin, pin_oe, rdy_n;
	logic        cont, start, restart, pv, av, pnew, anew, ireset;
	logic [7:0]  cfg, seen_b, rxv, st;
	logic [5:0]  misc;
	logic [31:0] pdata, d, d2;
	logic [23:0] adata;
	logic [7:0]  exp_q[$];
	event        got_ev;
	int          mismatches, checked, n, bad;

	always #2.5 clock_i = ~clock_i;

	asri_top #(.TIMEOUT_CYC(TO), .CHK_SEED(SEED)) asri_top_inst (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.serial_in_i(din), .serial_out_ready_combined_o(pin),
		.serial_out_ready_combined_oe_o(pin_oe), .conversion_ready_n_o(rdy_n),
		.iface_cfg_i(cfg), .continuous_mode_i(cont), .conv_start_i(start),
		.conv_restart_i(restart), .status_misc_i(misc), .primary_valid_i(pv),
		.primary_data_i(pdata), .auxiliary_valid_i(av), .auxiliary_data_i(adata),
		.primary_new_o(pnew), .auxiliary_new_o(anew), .iface_reset_o(ireset));

	asri_host_model asri_host_model_inst (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
		.dout_i(pin), .dout_oe_i(pin_oe));

	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic xb(input logic [7:0] tx, input logic cmp, input logic [7:0] e);
		if (cmp)
			exp_q.push_back(e);
		asri_host_model_inst.bits(tx, 8, rxv);
		if (cmp) begin
			seen_b = rxv;
			->got_ev;
		end
	endtask

	task automatic rd(input logic [47:0] fr, input int k);
		for (int i = 0; i < k; i++)
			xb(8'h00, 1'b1, fr[47 - 8 * i -: 8]);
	endtask

	task automatic res(input logic [31:0] v);
		tick(1);
		pdata = v;
		pv = 1'b1;
		tick(1);
		pv = 1'b0;
	endtask

	task automatic cmd(input logic [7:0] c);
		asri_host_model_inst.sel(1'b1);
		asri_host_model_inst.sel(1'b0);
		xb(c, 1'b0, 8'h00);
	endtask

	function automatic logic [7:0] ck(input logic [31:0] v);
		return v[31:24] + v[23:16] + v[15:8] + v[7:0] + SEED;
	endfunction

	always @(got_ev) chk({24'h0, seen_b}, {24'h0, exp_q.pop_front()});

	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{clock_i, rst_n_i, start, restart, pv, av} = '0;
		cont = 1'b1;
		void'($urandom(39041));
		pdata = $urandom;
		adata = 24'($urandom);
		cfg = {4'($urandom), 4'h0};
		misc = 6'($urandom);
		tick(16);
		rst_n_i = 1'b1;
		tick(3);
		chk(rdy_n, 1);
		chk(pin_oe, 0);
		cfg = {4'($urandom), 2'b01, 2'($urandom_range(3, 1))};
		asri_host_model_inst.sel(1'b0);
		chk(pin_oe, 1);
		d = $urandom;
		res(d);
		tick(1);
		chk(pin, 0);
		chk(pnew, 1);
		st = {2'b01, misc};
		// Quiet link until readback starts
		rd({st, d, ck(d)}, 6);
		xb(8'h00, 1'b1, st);
		chk(rdy_n, 1);
		chk(pnew, 0);
		asri_host_model_inst.sel(1'b1);
		res($urandom);
		tick(30);
		d2 = $urandom;
		res(d2);
		tick(15);
		chk(rdy_n, 1);
		tick(1);
		chk(rdy_n, 0);
		cmd(asri_pkg::CMD_READ_PRIMARY);
		xb(8'h00, 1'b0, 8'h00);
		rd({d2, ck(d2), 8'h00}, 5);
		cmd(asri_pkg::CMD_READ_PRIMARY);
		rd({2'b00, misc, d2, ck(d2)}, 6);
		tick(1);
		adata = 24'($urandom);
		av = 1'b1;
		tick(1);
		av = 1'b0;
		tick(1);
		chk(anew, 1);
		cmd(asri_pkg::CMD_READ_AUX);
		rd({2'b10, misc, adata, 8'h00, ck({adata, 8'h00})}, 6);
		asri_host_model_inst.sel(1'b1);
		chk(anew, 0);
		// Result landing mid-byte
		cfg = {4'($urandom), 4'h0};
		asri_host_model_inst.sel(1'b0);
		d = $urandom;
		res(d);
		asri_host_model_inst.bits(8'h00, 4, rxv);
		d2 = $urandom;
		res(d2);
		asri_host_model_inst.bits(8'h00, 4, rxv);
		asri_host_model_inst.sel(1'b1);
		asri_host_model_inst.sel(1'b0);
		rd({d, 16'h0}, 4);
		xb(8'h00, 1'b1, d[31:24]);
		cmd(8'h13);
		rd({d2, 16'h0}, 4);
		asri_host_model_inst.sel(1'b1);
		res($urandom);
		restart = 1'b1;
		tick(1);
		restart = 1'b0;
		tick(2);
		chk(pnew, 0);
		cmd(asri_pkg::CMD_READ_PRIMARY);
		rd(48'h0, 4);
		tick(1);
		cont = 1'b0;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		tick(1);
		chk(rdy_n, 1);
		d = $urandom;
		res(d);
		tick(1);
		xb(8'h00, 1'b0, 8'h00);
		tick(8);
		chk(rdy_n, 0);
		start = 1'b1;
		tick(1);
		start = 1'b0;
		tick(1);
		chk(rdy_n, 1);
		// Stray edge with autoreset off
		asri_host_model_inst.sel(1'b1);
		asri_host_model_inst.sel(1'b0);
		asri_host_model_inst.bits(8'h00, 1, rxv);
		bad = 0;
		for (n = 0; n < TO + 40; n++) begin
			tick(1);
			bad += int'(ireset !== 1'b0);
		end
		chk(bad, 0);
		cfg = {4'($urandom), 4'h8};
		asri_host_model_inst.sel(1'b1);
		asri_host_model_inst.sel(1'b0);
		// clock held low after the stray edge
		asri_host_model_inst.bits(8'h00, 1, rxv);
		for (n = 0; n < TO + 40 && ireset !== 1'b1; n++)
			tick(1);
		chk(32'(n >= TO - 16 && n <= TO + 8), 1);
		if (n == TO + 40)
			end_of_test();
		tick(9);
		xb(asri_pkg::CMD_READ_PRIMARY, 1'b0, 8'h00);
		rd({d, 16'h0}, 4);
		tick(10);
		end_of_test();
	end
endmodule

bind asri_top asri_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) asri_assertions_inst (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
	.serial_in_i(serial_in_i), .serial_out_ready_combined_o(serial_out_ready_combined_o),
	.serial_out_ready_combined_oe_o(serial_out_ready_combined_oe_o),
	.conversion_ready_n_o(conversion_ready_n_o), .iface_cfg_i(iface_cfg_i),
	.continuous_mode_i(continuous_mode_i), .conv_start_i(conv_start_i),
	.conv_restart_i(conv_restart_i), .status_misc_i(status_misc_i),
	.primary_valid_i(primary_valid_i), .primary_data_i(primary_data_i),
	.auxiliary_valid_i(auxiliary_valid_i), .auxiliary_data_i(auxiliary_data_i),
	.primary_new_o(primary_new_o), .auxiliary_new_o(auxiliary_new_o),
	.iface_reset_o(iface_reset_o));
